/* verilog/afpc_pkg.sv */
/*
 * Constants, field layout and carrier types for the alarm filter and
 * status pin configuration block.
 * Assumes a single MCLK domain and a synchronous active-high reset.
 */
// Contract
// - Enable bit 15 drives the status pin
// - Enable cleared leaves the pin undriven
// - Select 0 routes data-available to the pin
// - Select 1 routes converter-ready to the pin
// - Channel debounce code picks 1 to 256 samples
// - Local temperature code picks 1 to 8 samples
// - Remote 2 code picks 1 to 8 samples
// - Remote 1 code picks 1 to 8 samples
// - Arrangement bit 7 selects PNP remote sensing
// - Shutdown bit forces amplifier off on alarm
// - Amplifier stays off until alarm cleared
// - Shutdown bit 0 leaves amplifier untouched
package afpc_pkg;

    localparam int          ADDR_W      = 7;
    localparam int          DATA_W      = 16;
    localparam int          THR_W       = 9;
    localparam logic [6:0]  CFG_ONE_OFS = 7'h11;
    localparam logic [15:0] CFG_ONE_RST = 16'h036A;
    localparam logic [15:0] RD_NONE     = 16'h0000;
    localparam logic [8:0]  THR_ONE     = 9'h001;
    localparam logic [8:0]  CNT_ZERO    = 9'h000;
    localparam logic [8:0]  CNT_STEP    = 9'h001;

    typedef struct packed {
        logic       pin_enable;
        logic       pin_select;
        logic [2:0] reserved;
        logic [2:0] ch_debounce;
        logic       remote_pnp;
        logic       supply_shutdown;
        logic [1:0] lt_debounce;
        logic [1:0] rt2_debounce;
        logic [1:0] rt1_debounce;
    } afpc_cfg_t;

    // One sample of a monitored quantity, on the same clock as this block
    typedef struct packed {
        logic valid;
        logic out_range;
    } afpc_smp_t;

    typedef enum logic [2:0] {
        AS_ARMED   = 3'h1,
        AS_TRIPPED = 3'h2,
        AS_BYPASS  = 3'h4
    } afpc_amp_t;

    // Codes 0..7 give 1, 4, 8 ... 256 consecutive samples
    function automatic logic [8:0] ch_thresh(input logic [2:0] code);
        logic [8:0] t;
        // Widen the shift amount first: code 7 plus one must not wrap to zero
        t = (code == 3'h0) ? THR_ONE : (THR_ONE << ({1'b0, code} + 4'h1));
        return t;
    endfunction

    // Codes 0..3 give 1, 2, 4, 8 consecutive samples
    function automatic logic [8:0] temp_thresh(input logic [1:0] code);
        logic [8:0] t;
        t = THR_ONE << code;
        return t;
    endfunction

endpackage

/* verilog/afpc_debounce.sv */
/*
 * Consecutive out-of-range sample counter for one monitored quantity.
 * Assumes samples and threshold are on MCLK; threshold is at least one.
 */
`timescale 1ns/1ps
module afpc_debounce #(
    parameter int THR_W = 9
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire afpc_pkg::afpc_smp_t smp,
    input  wire logic [THR_W-1:0] thresh,
    output logic                  alarm
);
    logic [THR_W-1:0] cnt_q;
    logic [THR_W-1:0] cnt_d;
    logic             alarm_q;
    logic             alarm_d;
    logic [THR_W-1:0] cnt_inc;

    if (THR_W < 2) begin : g_chk
        $error("afpc_debounce: THR_W too small");
    end

    always_comb begin
        cnt_inc = cnt_q + THR_W'(1);
        cnt_d   = cnt_q;
        alarm_d = alarm_q;
        if (smp.valid && smp.out_range) begin
            // Saturate at the threshold so long runs cannot wrap
            if (cnt_q < thresh) begin
                cnt_d = cnt_inc;
            end
            if (cnt_inc >= thresh) begin
                alarm_d = 1'b1;
            end
        end else if (smp.valid) begin
            cnt_d   = '0;
            alarm_d = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_q   <= '0;
            alarm_q <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            alarm_q <= alarm_d;
        end
    end

    assign alarm = alarm_q;

    chk_run_restart: assert property (@(posedge mclk) disable iff (rst)
        smp.valid && !smp.out_range |=> !alarm_q && cnt_q == '0)
        else $error("in-range sample did not restart the run");

    chk_run_short: assert property (@(posedge mclk) disable iff (rst)
        smp.valid && smp.out_range && !alarm_q && (cnt_q + THR_W'(1)) < thresh
        |=> !alarm_q)
        else $error("alarm raised before the run was long enough");

    chk_run_reach: assert property (@(posedge mclk) disable iff (rst)
        smp.valid && smp.out_range && (cnt_q + THR_W'(1)) >= thresh |=> alarm_q)
        else $error("alarm missed at the end of the run");

endmodule

/* verilog/afpc_status_pin.sv */
/*
 * Shared status pin driver: picks data-available or converter-ready
 * and drives or releases the pin.
 * Assumes both indications come from logic on MCLK.
 */
`timescale 1ns/1ps
module afpc_status_pin (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic pin_enable,
    input  wire logic pin_select,
    input  wire logic data_available_flag,
    input  wire logic adc_ready_flag,
    output logic      pin_o,
    output logic      pin_oe
);
    logic o_q;
    logic o_d;
    logic oe_q;
    logic oe_d;

    always_comb begin
        oe_d = pin_enable;
        o_d  = 1'b0;
        if (pin_enable) begin
            o_d = pin_select ? adc_ready_flag : data_available_flag;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            o_q  <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            o_q  <= o_d;
            oe_q <= oe_d;
        end
    end

    assign pin_o  = o_q;
    assign pin_oe = oe_q;

endmodule

/* verilog/afpc_top.sv */
/*
 * Alarm filter and status pin configuration register with the logic
 * that its fields steer: status pin, alarm debounce, remote sensor
 * arrangement and supply-alarm shutdown of the amplifier enable.
 * Assumes a register port decoded from the serial interface on MCLK,
 * and alarm samples, supply alarm and amplifier request on MCLK too.
 */
`timescale 1ns/1ps
module afpc_top #(
    parameter int N_ADC = 4
) (
    input  wire logic                          MCLK,
    input  wire logic                          RST,
    input  wire logic                          REG_WR_EN,
    input  wire logic                          REG_RD_EN,
    input  wire logic [afpc_pkg::ADDR_W-1:0]   REG_ADDR,
    input  wire logic [afpc_pkg::DATA_W-1:0]   REG_WDATA,
    output logic      [afpc_pkg::DATA_W-1:0]   REG_RDATA,
    input  wire logic                          DATA_AVAIL,
    input  wire logic                          ADC_READY,
    output logic                               STATUS_PIN_O,
    output logic                               STATUS_PIN_OE,
    input  wire afpc_pkg::afpc_smp_t [N_ADC-1:0] CH_SMP,
    input  wire afpc_pkg::afpc_smp_t           LT_SMP,
    input  wire afpc_pkg::afpc_smp_t           RT1_SMP,
    input  wire afpc_pkg::afpc_smp_t           RT2_SMP,
    output logic      [N_ADC-1:0]              CH_ALARM,
    output logic                               LT_ALARM,
    output logic                               RT1_ALARM,
    output logic                               RT2_ALARM,
    output logic                               REMOTE_PNP,
    input  wire logic                          NEG_SUPPLY_ALARM,
    input  wire logic                          AMP_ON_REQ,
    output logic                               AMP_EN
);
    afpc_pkg::afpc_cfg_t              cfg_q;
    afpc_pkg::afpc_cfg_t              cfg_d;
    logic [afpc_pkg::DATA_W-1:0]      rdata_q;
    logic [afpc_pkg::DATA_W-1:0]      rdata_d;
    logic                             pnp_q;
    logic                             pnp_d;
    afpc_pkg::afpc_amp_t              amp_st_q;
    afpc_pkg::afpc_amp_t              amp_st_d;
    logic                             amp_q;
    logic                             amp_d;
    logic [afpc_pkg::THR_W-1:0]       ch_thr;
    logic [afpc_pkg::THR_W-1:0]       lt_thr;
    logic [afpc_pkg::THR_W-1:0]       rt1_thr;
    logic [afpc_pkg::THR_W-1:0]       rt2_thr;
    logic                             sel_hit;

    if (N_ADC < 1 || N_ADC > 16) begin : g_chk
        $error("afpc_top: N_ADC out of range");
    end

    // Register port
    assign sel_hit = (REG_ADDR == afpc_pkg::CFG_ONE_OFS);

    function automatic logic [afpc_pkg::DATA_W-1:0] cfg_word(input afpc_pkg::afpc_cfg_t c);
        return c;
    endfunction

    always_comb begin
        cfg_d   = cfg_q;
        rdata_d = rdata_q;
        if (REG_WR_EN && sel_hit) begin
            // Reserved bits are stored as written; keeping them zero is the host's job
            cfg_d = afpc_pkg::afpc_cfg_t'(REG_WDATA);
        end
        if (REG_RD_EN) begin
            rdata_d = sel_hit ? cfg_word(cfg_q) : afpc_pkg::RD_NONE;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            cfg_q   <= afpc_pkg::afpc_cfg_t'(afpc_pkg::CFG_ONE_RST);
            rdata_q <= afpc_pkg::RD_NONE;
        end else begin
            cfg_q   <= cfg_d;
            rdata_q <= rdata_d;
        end
    end

    assign REG_RDATA = rdata_q;

    // Shared status pin
    afpc_status_pin u_pin (
        .mclk                (MCLK),
        .rst                 (RST),
        .pin_enable          (cfg_q.pin_enable),
        .pin_select          (cfg_q.pin_select),
        .data_available_flag (DATA_AVAIL),
        .adc_ready_flag      (ADC_READY),
        .pin_o               (STATUS_PIN_O),
        .pin_oe              (STATUS_PIN_OE)
    );

    // Debounce thresholds
    assign ch_thr  = afpc_pkg::ch_thresh(cfg_q.ch_debounce);
    assign lt_thr  = afpc_pkg::temp_thresh(cfg_q.lt_debounce);
    assign rt2_thr = afpc_pkg::temp_thresh(cfg_q.rt2_debounce);
    assign rt1_thr = afpc_pkg::temp_thresh(cfg_q.rt1_debounce);

    for (genvar i = 0; i < N_ADC; i++) begin : g_ch
        afpc_debounce #(.THR_W(afpc_pkg::THR_W)) u_db (
            .mclk   (MCLK),
            .rst    (RST),
            .smp    (CH_SMP[i]),
            .thresh (ch_thr),
            .alarm  (CH_ALARM[i])
        );
    end

    afpc_debounce #(.THR_W(afpc_pkg::THR_W)) u_lt (
        .mclk   (MCLK),
        .rst    (RST),
        .smp    (LT_SMP),
        .thresh (lt_thr),
        .alarm  (LT_ALARM)
    );

    afpc_debounce #(.THR_W(afpc_pkg::THR_W)) u_rt1 (
        .mclk   (MCLK),
        .rst    (RST),
        .smp    (RT1_SMP),
        .thresh (rt1_thr),
        .alarm  (RT1_ALARM)
    );

    afpc_debounce #(.THR_W(afpc_pkg::THR_W)) u_rt2 (
        .mclk   (MCLK),
        .rst    (RST),
        .smp    (RT2_SMP),
        .thresh (rt2_thr),
        .alarm  (RT2_ALARM)
    );

    // Remote sensor arrangement
    always_comb begin
        pnp_d = cfg_q.remote_pnp;
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            pnp_q <= 1'b0;
        end else begin
            pnp_q <= pnp_d;
        end
    end

    assign REMOTE_PNP = pnp_q;

    // Amplifier enable: the alarm acts in the same cycle it is seen, ahead of any request
    always_comb begin
        amp_st_d = amp_st_q;
        case (amp_st_q)
            afpc_pkg::AS_ARMED: begin
                if (!cfg_q.supply_shutdown) begin
                    amp_st_d = afpc_pkg::AS_BYPASS;
                end else if (NEG_SUPPLY_ALARM) begin
                    amp_st_d = afpc_pkg::AS_TRIPPED;
                end
            end
            afpc_pkg::AS_TRIPPED: begin
                if (!cfg_q.supply_shutdown) begin
                    amp_st_d = afpc_pkg::AS_BYPASS;
                end else if (!NEG_SUPPLY_ALARM) begin
                    amp_st_d = afpc_pkg::AS_ARMED;
                end
            end
            afpc_pkg::AS_BYPASS: begin
                if (cfg_q.supply_shutdown) begin
                    amp_st_d = NEG_SUPPLY_ALARM ? afpc_pkg::AS_TRIPPED
                                                : afpc_pkg::AS_ARMED;
                end
            end
            default: begin
                amp_st_d = afpc_pkg::AS_ARMED;
            end
        endcase
        amp_d = AMP_ON_REQ && (amp_st_d != afpc_pkg::AS_TRIPPED);
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            amp_st_q <= afpc_pkg::AS_ARMED;
            amp_q    <= 1'b0;
        end else begin
            amp_st_q <= amp_st_d;
            amp_q    <= amp_d;
        end
    end

    assign AMP_EN = amp_q;

    sequence s_trip;
        cfg_q.supply_shutdown && NEG_SUPPLY_ALARM;
    endsequence

    sequence s_still_alarmed;
        (amp_st_q == afpc_pkg::AS_TRIPPED) && cfg_q.supply_shutdown && NEG_SUPPLY_ALARM;
    endsequence

    chk_pin_driven: assert property (@(posedge MCLK) disable iff (RST)
        cfg_q.pin_enable |=> STATUS_PIN_OE)
        else $error("status pin not driven while enabled");

    chk_pin_released: assert property (@(posedge MCLK) disable iff (RST)
        !cfg_q.pin_enable |=> !STATUS_PIN_OE && !STATUS_PIN_O)
        else $error("status pin driven while disabled");

    chk_pin_dav: assert property (@(posedge MCLK) disable iff (RST)
        cfg_q.pin_enable && !cfg_q.pin_select |=> STATUS_PIN_O == $past(DATA_AVAIL))
        else $error("status pin does not carry data-available");

    chk_pin_rdy: assert property (@(posedge MCLK) disable iff (RST)
        cfg_q.pin_enable && cfg_q.pin_select |=> STATUS_PIN_O == $past(ADC_READY))
        else $error("status pin does not carry converter-ready");

    chk_ch_thresh: assert property (@(posedge MCLK) disable iff (RST)
        cfg_q.ch_debounce == 3'h3 |-> ch_thr == 9'h010)
        else $error("default channel run length is not 16");

    chk_temp_thresh: assert property (@(posedge MCLK) disable iff (RST)
        cfg_q.rt2_debounce == 2'h3 |-> rt2_thr == 9'h008 && rt1_thr <= 9'h008)
        else $error("temperature run length decode wrong");

    chk_pnp_follow: assert property (@(posedge MCLK) disable iff (RST)
        ##1 REMOTE_PNP == $past(cfg_q.remote_pnp))
        else $error("sensor arrangement does not follow its bit");

    chk_trip_off: assert property (@(posedge MCLK) disable iff (RST)
        s_trip |=> !AMP_EN)
        else $error("amplifier not forced off by supply alarm");

    chk_hold_off: assert property (@(posedge MCLK) disable iff (RST)
        s_still_alarmed ##1 s_still_alarmed |=> !AMP_EN)
        else $error("amplifier returned on before alarm cleared");

    chk_no_trip: assert property (@(posedge MCLK) disable iff (RST)
        !cfg_q.supply_shutdown |=> AMP_EN == $past(AMP_ON_REQ))
        else $error("amplifier changed by alarm with shutdown off");

    // Run lengths spelled out per code so a wrong shift in the decode cannot hide
    chk_ch_table: assert property (@(posedge MCLK) disable iff (RST)
        (cfg_q.ch_debounce == 3'h0 && ch_thr == 9'h001) ||
        (cfg_q.ch_debounce == 3'h1 && ch_thr == 9'h004) ||
        (cfg_q.ch_debounce == 3'h2 && ch_thr == 9'h008) ||
        (cfg_q.ch_debounce == 3'h3 && ch_thr == 9'h010) ||
        (cfg_q.ch_debounce == 3'h4 && ch_thr == 9'h020) ||
        (cfg_q.ch_debounce == 3'h5 && ch_thr == 9'h040) ||
        (cfg_q.ch_debounce == 3'h6 && ch_thr == 9'h080) ||
        (cfg_q.ch_debounce == 3'h7 && ch_thr == 9'h100))
        else $error("channel run length decode wrong");

    chk_lt_table: assert property (@(posedge MCLK) disable iff (RST)
        (cfg_q.lt_debounce == 2'h0 && lt_thr == 9'h001) ||
        (cfg_q.lt_debounce == 2'h1 && lt_thr == 9'h002) ||
        (cfg_q.lt_debounce == 2'h2 && lt_thr == 9'h004) ||
        (cfg_q.lt_debounce == 2'h3 && lt_thr == 9'h008))
        else $error("local temperature run length decode wrong");

    chk_rt2_table: assert property (@(posedge MCLK) disable iff (RST)
        (cfg_q.rt2_debounce == 2'h0 && rt2_thr == 9'h001) ||
        (cfg_q.rt2_debounce == 2'h1 && rt2_thr == 9'h002) ||
        (cfg_q.rt2_debounce == 2'h2 && rt2_thr == 9'h004) ||
        (cfg_q.rt2_debounce == 2'h3 && rt2_thr == 9'h008))
        else $error("remote 2 run length decode wrong");

    chk_rt1_table: assert property (@(posedge MCLK) disable iff (RST)
        (cfg_q.rt1_debounce == 2'h0 && rt1_thr == 9'h001) ||
        (cfg_q.rt1_debounce == 2'h1 && rt1_thr == 9'h002) ||
        (cfg_q.rt1_debounce == 2'h2 && rt1_thr == 9'h004) ||
        (cfg_q.rt1_debounce == 2'h3 && rt1_thr == 9'h008))
        else $error("remote 1 run length decode wrong");

    sequence s_cfg_read;
        REG_RD_EN && sel_hit;
    endsequence

    chk_rd_hit: assert property (@(posedge MCLK) disable iff (RST)
        s_cfg_read |=> REG_RDATA == $past(cfg_q))
        else $error("read of the configuration returned other data");

    chk_rd_miss: assert property (@(posedge MCLK) disable iff (RST)
        REG_RD_EN && !sel_hit |=> REG_RDATA == afpc_pkg::RD_NONE)
        else $error("read of another address returned data");

    chk_wr_other: assert property (@(posedge MCLK) disable iff (RST)
        !(REG_WR_EN && sel_hit) |=> cfg_q == $past(cfg_q))
        else $error("configuration changed without a write to it");

    chk_wr_land: assert property (@(posedge MCLK) disable iff (RST)
        REG_WR_EN && sel_hit |=> cfg_q == $past(REG_WDATA))
        else $error("write to the configuration did not land");

    sequence s_cleared;
        (amp_st_q == afpc_pkg::AS_TRIPPED) && cfg_q.supply_shutdown && !NEG_SUPPLY_ALARM;
    endsequence

    chk_rearm_on: assert property (@(posedge MCLK) disable iff (RST)
        s_cleared |=> AMP_EN == $past(AMP_ON_REQ))
        else $error("amplifier request ignored after alarm cleared");

endmodule

/* bench/afpc_host.sv */
/*
 * Host controller model: register writes and reads on the decoded
 * register port of the configuration block.
 * Assumes one-cycle strobes sampled on the rising MCLK edge and read
 * data that is valid by the falling edge after the sampling edge.
 */
`timescale 1ns/1ps
module afpc_host (
    input  wire logic        mclk,
    input  wire logic [15:0] rdata,
    output logic             wr_en,
    output logic             rd_en,
    output logic [6:0]       addr,
    output logic [15:0]      wdata
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr  = 7'h00;
        wdata = 16'h0000;
    end

    // Factory bits are never set by a well-behaved host
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d & 16'hC7FF;
        @(posedge mclk);
        wr_en <= 1'b0;
        wdata <= ~d;
    endtask

    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        @(posedge mclk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge mclk);
        rd_en <= 1'b0;
        @(negedge mclk);
        d = rdata;
    endtask
endmodule

/* bench/tb_alarm_filter_pin_config.sv */
/*
 * Self-checking testbench of the configuration block: register reset
 * and access, status pin, alarm debounce, sensor arrangement, shutdown.
 * Assumes the host model in afpc_host and the design package.
 */
`timescale 1ns/1ps
module tb_alarm_filter_pin_config;
    logic                      mclk;
    logic                      rst;
    logic                      da;
    logic                      ar;
    logic                      nsa;
    logic                      req;
    logic [1:0]                ts;
    afpc_pkg::afpc_smp_t [3:0] ch;
    logic                      wr_en;
    logic                      rd_en;
    logic [6:0]                addr;
    logic [15:0]               wdata;
    logic [15:0]               rdata;
    logic                      pin_o;
    logic                      pin_oe;
    logic                      pnp;
    logic                      amp_en;
    logic                      lt_a;
    logic                      rt1_a;
    logic                      rt2_a;
    logic [3:0]                ch_a;
    int                        n_fail = 0;
    int                        checked = 0;

    always #25 mclk = ~mclk;

    afpc_host host (.mclk(mclk), .rdata(rdata), .wr_en(wr_en), .rd_en(rd_en),
                    .addr(addr), .wdata(wdata));

    afpc_top #(.N_ADC(4)) dut (
        .MCLK(mclk), .RST(rst), .REG_WR_EN(wr_en), .REG_RD_EN(rd_en),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
        .DATA_AVAIL(da), .ADC_READY(ar), .STATUS_PIN_O(pin_o),
        .STATUS_PIN_OE(pin_oe), .CH_SMP(ch), .LT_SMP(ts), .RT1_SMP(ts),
        .RT2_SMP(ts), .CH_ALARM(ch_a), .LT_ALARM(lt_a), .RT1_ALARM(rt1_a),
        .RT2_ALARM(rt2_a), .REMOTE_PNP(pnp), .NEG_SUPPLY_ALARM(nsa),
        .AMP_ON_REQ(req), .AMP_EN(amp_en));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic t_regs;
        logic [15:0] d;
        host.rd(7'h11, d);
        chk(d, 16'h036A);
        chk(16'({pin_oe, pin_o, amp_en, pnp}), 16'h0);
        host.wr(7'h11, 16'hFFFF);
        host.rd(7'h11, d);
        chk(d, 16'hC7FF);
        // Other addresses must neither land here nor read back data
        host.wr(7'h12, 16'h0000);
        host.rd(7'h11, d);
        chk(d, 16'hC7FF);
        host.rd(7'h12, d);
        chk(d, 16'h0000);
        $display("register test done");
    endtask

    task automatic t_pin;
        for (int i = 0; i < 16; i++) begin
            host.wr(7'h11, {i[3], i[2], 14'h036A});
            da <= i[1];
            ar <= i[0];
            cyc(3);
            if (i[3]) chk(16'(pin_oe), 16'h1);
            else chk(16'(pin_oe), 16'h0);
            if (i[2]) chk(16'(pin_o), 16'(i[3] & i[0]));
            else chk(16'(pin_o), 16'(i[3] & i[1]));
        end
        $display("status pin test done");
    endtask

    // A short run broken by an in-range sample must not count on
    task automatic t_deb;
        int thc;
        int tl;
        int t2;
        int t1;
        int top;
        for (int c = 0; c < 8; c++) begin
            host.wr(7'h11, {5'h00, 3'(c), 2'b01, 2'(c), 2'(c + 1), 2'(c + 2)});
            thc = (c == 0) ? 1 : (2 << c);
            tl  = 1 << (c % 4);
            t2  = 1 << ((c + 1) % 4);
            t1  = 1 << ((c + 2) % 4);
            top = (thc > 8) ? thc : 8;
            repeat (thc - 1) begin
                @(posedge mclk);
                ch <= {4{2'b11}};
                ts <= 2'b11;
            end
            @(posedge mclk);
            ch <= {4{2'b10}};
            ts <= 2'b10;
            for (int n = 1; n <= top + 1; n++) begin
                @(posedge mclk);
                ch <= {4{1'b1, 1'(n <= top)}};
                ts <= {1'b1, 1'(n <= top)};
                @(negedge mclk);
                chk(16'(ch_a), (n - 1 >= thc) ? 16'h000F : 16'h0000);
                chk(16'(lt_a), 16'(n - 1 >= tl));
                chk(16'(rt2_a), 16'(n - 1 >= t2));
                chk(16'(rt1_a), 16'(n - 1 >= t1));
            end
            @(posedge mclk);
            ch <= {4{2'b00}};
            ts <= 2'b00;
            @(negedge mclk);
            chk(16'({ch_a, lt_a, rt2_a, rt1_a}), 16'h0);
        end
        $display("debounce test done");
    endtask

    task automatic t_pnp;
        host.wr(7'h11, 16'h03EA);
        cyc(3);
        chk(16'(pnp), 16'h1);
        host.wr(7'h11, 16'h036A);
        cyc(3);
        chk(16'(pnp), 16'h0);
        $display("sensor arrangement test done");
    endtask

    task automatic t_amp;
        host.wr(7'h11, 16'h036A);
        req <= 1'b1;
        cyc(3);
        chk(16'(amp_en), 16'h1);
        @(posedge mclk);
        nsa <= 1'b1;
        cyc(1);
        chk(16'(amp_en), 16'h0);
        cyc(4);
        chk(16'(amp_en), 16'h0);
        @(posedge mclk);
        nsa <= 1'b0;
        cyc(1);
        chk(16'(amp_en), 16'h1);
        host.wr(7'h11, 16'h032A);
        nsa <= 1'b1;
        cyc(3);
        chk(16'(amp_en), 16'h1);
        // Re-arming the shutdown while the alarm stands must trip at once
        host.wr(7'h11, 16'h036A);
        cyc(1);
        chk(16'(amp_en), 16'h0);
        host.wr(7'h11, 16'h032A);
        cyc(1);
        chk(16'(amp_en), 16'h1);
        @(posedge mclk);
        req <= 1'b0;
        cyc(1);
        chk(16'(amp_en), 16'h0);
        @(posedge mclk);
        nsa <= 1'b0;
        $display("shutdown test done");
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #1_000_000;
        n_fail++;
        summarize;
    end

    initial begin
        mclk = 1'b0;
        rst  = 1'b1;
        da   = 1'b0;
        ar   = 1'b0;
        nsa  = 1'b0;
        req  = 1'b0;
        ts   = 2'b00;
        ch   = '0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        t_regs;
        t_pin;
        t_deb;
        t_pnp;
        t_amp;
        summarize;
    end
endmodule
